// ### verilog/pbc_blend.v
// Purpose: pre-blend clamp and colour blend of one pixel per cycle
// Assumes: state inputs are held stable while pixels flow
// Notes: post-blend clamp, gamma and logic ops live elsewhere
`timescale 1ns/1ps
`include "pbc_regs.vh"
module pbc_blend (
  // Clock, reset, enable
  input wire core_clk_i,
  input wire rst_b_i,
  input wire ce_i,
  // Shared state record
  input wire glb_blend_en_i,
  input wire pre_clamp_en_i,
  input wire [1:0] clamp_range_i,
  input wire ind_alpha_en_i,
  input wire [4:0] src_factor_i,
  input wire [4:0] dst_factor_i,
  input wire [2:0] color_func_i,
  input wire [4:0] src_alpha_factor_i,
  input wire [4:0] dst_alpha_factor_i,
  input wire [2:0] alpha_func_i,
  input wire [63:0] const_color_i,
  input wire early_stepping_i,
  // Pixel in from shader output
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [63:0] src_color_i,
  input wire [63:0] second_source_output_i,
  input wire dual_source_i,
  input wire [63:0] dst_color_i,
  input wire rt_blend_en_i,
  input wire [2:0] rt_format_i,
  input wire rt_has_alpha_i,
  // Pixel out to data port
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [63:0] out_color_o
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function [15:0] clamp16;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      if ($signed(v) < $signed(lo)) begin
        clamp16 = lo;
      end else if ($signed(v) > $signed(hi)) begin
        clamp16 = hi;
      end else begin
        clamp16 = v;
      end
    end
  endfunction

  // Bound of a format; hi selects upper bound
  function [15:0] fmt_bound;
    input [2:0] fmt;
    input hi;
    begin
      case (fmt)
        `PBC_FMT_UNORM: fmt_bound = hi ? `PBC_ONE : `PBC_ZERO;
        `PBC_FMT_SNORM: fmt_bound = hi ? `PBC_ONE : `PBC_NEG_ONE;
        `PBC_FMT_PSF: fmt_bound = hi ? `PBC_MAXV : `PBC_ZERO;
        `PBC_FMT_UINT: fmt_bound = hi ? `PBC_MAXV : `PBC_ZERO;
        default: fmt_bound = hi ? `PBC_MAXV : `PBC_MINV;
      endcase
    end
  endfunction

  function [15:0] sel_bound;
    input [1:0] rng;
    input [2:0] fmt;
    input hi;
    begin
      if (rng == `PBC_RNG_UNIT) begin
        sel_bound = hi ? `PBC_ONE : `PBC_ZERO;
      end else if (rng == `PBC_RNG_SIGNED) begin
        sel_bound = hi ? `PBC_ONE : `PBC_NEG_ONE;
      end else begin
        sel_bound = fmt_bound(fmt, hi);
      end
    end
  endfunction

  // Clamp all four components of a pixel
  function [63:0] clamp_px;
    input [63:0] px;
    input [15:0] lo;
    input [15:0] hi;
    integer k;
    begin
      clamp_px = px;
      for (k = 0; k < 4; k = k + 1) begin
        clamp_px[k*16 +: 16] = clamp16(px[k*16 +: 16], lo, hi);
      end
    end
  endfunction

  function [15:0] inv;
    input [15:0] v;
    begin
      inv = `PBC_ONE - v;
    end
  endfunction

  // Factor for one channel; second source only valid when dual
  function [15:0] factor;
    input [4:0] code;
    input [15:0] sc;
    input [15:0] sa;
    input [15:0] dc;
    input [15:0] da;
    input [15:0] cc;
    input [15:0] ca;
    input [15:0] s1c;
    input [15:0] s1a;
    input is_alpha;
    input dual;
    reg [15:0] f;
    begin
      f = `PBC_ZERO;
      case (code)
        `PBC_BF_ONE: factor = `PBC_ONE;
        `PBC_BF_SRC_C: factor = sc;
        `PBC_BF_INV_SRC_C: factor = inv(sc);
        `PBC_BF_SRC_A: factor = sa;
        `PBC_BF_INV_SRC_A: factor = inv(sa);
        `PBC_BF_DST_C: factor = dc;
        `PBC_BF_INV_DST_C: factor = inv(dc);
        `PBC_BF_DST_A: factor = da;
        `PBC_BF_INV_DST_A: factor = inv(da);
        `PBC_BF_CC_C: factor = cc;
        `PBC_BF_INV_CC_C: factor = inv(cc);
        `PBC_BF_CC_A: factor = ca;
        `PBC_BF_INV_CC_A: factor = inv(ca);
        `PBC_BF_SAT: begin
          f = ($signed(inv(da)) < $signed(sa)) ? inv(da) : sa;
          factor = is_alpha ? `PBC_ONE : f;
        end
        `PBC_BF_S1_C: factor = dual ? s1c : `PBC_ZERO;
        `PBC_BF_INV_S1_C: factor = dual ? inv(s1c) : `PBC_ZERO;
        `PBC_BF_S1_A: factor = dual ? s1a : `PBC_ZERO;
        `PBC_BF_INV_S1_A: factor = dual ? inv(s1a) : `PBC_ZERO;
        default: factor = `PBC_ZERO;
      endcase
    end
  endfunction

  // Combine two weighted terms, saturated to the component width
  function [15:0] combine;
    input [2:0] fn;
    input [31:0] st;
    input [31:0] dt;
    reg [31:0] r;
    begin
      case (fn)
        `PBC_FN_SUB: r = st - dt;
        `PBC_FN_RSUB: r = dt - st;
        `PBC_FN_MIN: r = ($signed(st) < $signed(dt)) ? st : dt;
        `PBC_FN_MAX: r = ($signed(st) > $signed(dt)) ? st : dt;
        default: r = st + dt;
      endcase
      if ($signed(r) > $signed({{16{1'b0}}, `PBC_MAXV})) begin
        combine = `PBC_MAXV;
      end else if ($signed(r) < $signed({{16{1'b1}}, `PBC_MINV})) begin
        combine = `PBC_MINV;
      end else begin
        combine = r[15:0];
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Operand stage
  // ----------------------------------------------------------------
  reg s1_v_q;
  reg [63:0] src_q;
  reg [63:0] dst_q;
  reg [63:0] cc_q;
  reg [63:0] sec_q;
  reg blend_q;
  reg has_alpha_q;
  reg dual_q;
  wire buf_ready;
  wire s1_ready;
  wire take;
  wire is_int;
  wire blend_on;
  wire clamp_src;
  wire clamp_blend_ops;
  wire [15:0] lo;
  wire [15:0] hi;

  // Early steppings treat every per-target enable as set
  assign blend_on = glb_blend_en_i &&
    (early_stepping_i || rt_blend_en_i);
  assign is_int = (rt_format_i == `PBC_FMT_UINT) ||
    (rt_format_i == `PBC_FMT_SINT);
  // Integer targets always clamp to their format bounds; others follow pre_clamp_en_i
  assign clamp_src = is_int || pre_clamp_en_i;
  assign clamp_blend_ops = blend_on && clamp_src;
  assign lo = is_int ? fmt_bound(rt_format_i, 1'b0) :
    sel_bound(clamp_range_i, rt_format_i, 1'b0);
  assign hi = is_int ? fmt_bound(rt_format_i, 1'b1) :
    sel_bound(clamp_range_i, rt_format_i, 1'b1);

  assign s1_ready = !s1_v_q || buf_ready;
  assign in_ready_o = ce_i && s1_ready;
  assign take = in_valid_i && in_ready_o;

  // Clamp lands in this register so the multiply sees clamped values
  always @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      s1_v_q <= 1'b0;
      src_q <= {`PBC_PW{1'b0}};
      dst_q <= {`PBC_PW{1'b0}};
      cc_q <= {`PBC_PW{1'b0}};
      sec_q <= {`PBC_PW{1'b0}};
      blend_q <= 1'b0;
      has_alpha_q <= 1'b0;
      dual_q <= 1'b0;
    end else if (ce_i && s1_ready) begin
      s1_v_q <= in_valid_i;
      if (take) begin
        src_q <= clamp_src ? clamp_px(src_color_i, lo, hi) :
          src_color_i;
        dst_q <= clamp_blend_ops ? clamp_px(dst_color_i, lo, hi) :
          dst_color_i;
        cc_q <= clamp_blend_ops ? clamp_px(const_color_i, lo, hi) :
          const_color_i;
        sec_q <= second_source_output_i;
        blend_q <= blend_on;
        has_alpha_q <= rt_has_alpha_i;
        dual_q <= dual_source_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // Blend datapath
  // ----------------------------------------------------------------
  wire [63:0] result;
  wire [15:0] dst_alpha;

  // Missing target alpha reads as one
  assign dst_alpha = has_alpha_q ? dst_q[63:48] : `PBC_ONE;

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : g_ch
      wire is_a;
      wire [4:0] sf_code;
      wire [4:0] df_code;
      wire [2:0] fn;
      wire [15:0] sc;
      wire [15:0] dc;
      wire [15:0] sfac;
      wire [15:0] dfac;
      wire signed [31:0] sprod;
      wire signed [31:0] dprod;
      wire [15:0] mix;
      assign is_a = (ch == `PBC_ALPHA_CH);
      // Alpha only switches to its own settings with independent alpha
      assign sf_code = (is_a && ind_alpha_en_i) ? src_alpha_factor_i :
        src_factor_i;
      assign df_code = (is_a && ind_alpha_en_i) ? dst_alpha_factor_i :
        dst_factor_i;
      assign fn = (is_a && ind_alpha_en_i) ? alpha_func_i :
        color_func_i;
      assign sc = src_q[ch*16 +: 16];
      assign dc = is_a ? dst_alpha : dst_q[ch*16 +: 16];
      assign sfac = factor(sf_code, sc, src_q[63:48], dc, dst_alpha,
        cc_q[ch*16 +: 16], cc_q[63:48], sec_q[ch*16 +: 16],
        sec_q[63:48], is_a, dual_q);
      assign dfac = factor(df_code, sc, src_q[63:48], dc, dst_alpha,
        cc_q[ch*16 +: 16], cc_q[63:48], sec_q[ch*16 +: 16],
        sec_q[63:48], is_a, dual_q);
      assign sprod = ($signed(sc) * $signed(sfac)) >>> `PBC_FRAC;
      assign dprod = ($signed(dc) * $signed(dfac)) >>> `PBC_FRAC;
      assign mix = combine(fn, sprod, dprod);
      if (ch == `PBC_ALPHA_CH) begin : g_alpha
        // No alpha is computed for a target without one
        assign result[ch*16 +: 16] = !blend_q ? sc :
          (has_alpha_q ? mix : `PBC_ONE);
      end else begin : g_rgb
        assign result[ch*16 +: 16] = blend_q ? mix : sc;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Output buffer
  // ----------------------------------------------------------------
  // Two entries keep a stalled data port from dropping a result
  pbc_skid2 #(
    .WIDTH(`PBC_PW)
  ) u_buf (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .in_valid_i(s1_v_q),
    .in_ready_o(buf_ready),
    .in_data_i(result),
    .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i),
    .out_data_o(out_color_o)
  );

endmodule // pbc_blend

// ### verilog/pbc_regs.vh
// Purpose: constants for the pixel pre-blend clamp and blend stage
// Assumes: colour components are signed 16-bit fixed point, 12 bits fraction
// Notes: encodings of formats, factors and functions are local to this block
`ifndef PBC_REGS_VH
`define PBC_REGS_VH

// ----------------------------------------------------------------
// Component format
// ----------------------------------------------------------------
`define PBC_CW 16
`define PBC_PW 64
`define PBC_FRAC 12
`define PBC_ZERO 16'h0000
`define PBC_ONE 16'h1000
`define PBC_NEG_ONE 16'hF000
`define PBC_MAXV 16'h7FFF
`define PBC_MINV 16'h8000
`define PBC_ALPHA_CH 3

// ----------------------------------------------------------------
// Clamp range select
// ----------------------------------------------------------------
`define PBC_RNG_UNIT 2'h0
`define PBC_RNG_SIGNED 2'h1
`define PBC_RNG_TARGET 2'h2

// ----------------------------------------------------------------
// Render-target formats
// ----------------------------------------------------------------
`define PBC_FMT_UNORM 3'h0
`define PBC_FMT_SNORM 3'h1
`define PBC_FMT_FLOAT 3'h2
`define PBC_FMT_PSF 3'h3
`define PBC_FMT_UINT 3'h4
`define PBC_FMT_SINT 3'h5

// ----------------------------------------------------------------
// Blend factors
// ----------------------------------------------------------------
`define PBC_BF_ZERO 5'h00
`define PBC_BF_ONE 5'h01
`define PBC_BF_SRC_C 5'h02
`define PBC_BF_INV_SRC_C 5'h03
`define PBC_BF_SRC_A 5'h04
`define PBC_BF_INV_SRC_A 5'h05
`define PBC_BF_DST_C 5'h06
`define PBC_BF_INV_DST_C 5'h07
`define PBC_BF_DST_A 5'h08
`define PBC_BF_INV_DST_A 5'h09
`define PBC_BF_CC_C 5'h0A
`define PBC_BF_INV_CC_C 5'h0B
`define PBC_BF_CC_A 5'h0C
`define PBC_BF_INV_CC_A 5'h0D
`define PBC_BF_SAT 5'h0E
`define PBC_BF_S1_C 5'h0F
`define PBC_BF_INV_S1_C 5'h10
`define PBC_BF_S1_A 5'h11
`define PBC_BF_INV_S1_A 5'h12

// ----------------------------------------------------------------
// Blend functions
// ----------------------------------------------------------------
`define PBC_FN_ADD 3'h0
`define PBC_FN_SUB 3'h1
`define PBC_FN_RSUB 3'h2
`define PBC_FN_MIN 3'h3
`define PBC_FN_MAX 3'h4

`endif

// ### verilog/pbc_skid2.v
// Purpose: two-entry buffer between blend result and data port
// Assumes: single clock, synchronous active-low reset
// Notes: depth fixed at two; full and empty are exact
`timescale 1ns/1ps
`include "pbc_regs.vh"
module pbc_skid2 #(
  parameter WIDTH = `PBC_PW
) (
  // Clock and reset
  input wire core_clk_i,
  input wire rst_b_i,
  input wire ce_i,
  // Fill side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  // Drain side
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);

  reg [WIDTH-1:0] mem_q [0:1];
  reg wr_ptr_q;
  reg rd_ptr_q;
  reg [1:0] count_q;
  wire push;
  wire pop;

  // ----------------------------------------------------------------
  // Handshake
  // ----------------------------------------------------------------
  assign in_ready_o = ce_i && (count_q != 2'h2);
  assign out_valid_o = (count_q != 2'h0);
  assign out_data_o = mem_q[rd_ptr_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = ce_i && out_valid_o && out_ready_i;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  always @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      mem_q[0] <= {WIDTH{1'b0}};
      mem_q[1] <= {WIDTH{1'b0}};
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
    end else if (ce_i) begin
      if (push) begin
        mem_q[wr_ptr_q] <= in_data_i;
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      if (push && !pop) begin
        count_q <= count_q + 2'h1;
      end else if (pop && !push) begin
        count_q <= count_q - 2'h1;
      end
    end
  end

endmodule // pbc_skid2

// ### verification/pbc_blend_chk.sv
// Purpose: port-level assertions for the pre-blend clamp and blend stage
// Assumes: state inputs held stable while pixels are in flight
// Notes: pixel checks only fire when the pipe was empty at capture
`timescale 1ns/1ps
`include "pbc_regs.vh"
module pbc_blend_chk (
  // Clock and reset
  input wire core_clk_i,
  input wire rst_b_i,
  input wire ce_i,
  // State
  input wire glb_blend_en_i,
  input wire pre_clamp_en_i,
  input wire [1:0] clamp_range_i,
  input wire early_stepping_i,
  input wire rt_blend_en_i,
  input wire [2:0] rt_format_i,
  // Streams
  input wire in_valid_i,
  input wire in_ready_o,
  input wire [63:0] src_color_i,
  input wire out_valid_o,
  input wire out_ready_i,
  input wire [63:0] out_color_o
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  reg prev_tk_q;
  reg prev_ce_q;
  wire tk = in_valid_i & in_ready_o;
  // Past edge neither took a pixel nor froze: stage known empty
  wire fresh = tk & !out_valid_o & !prev_tk_q & prev_ce_q;
  wire thru = !glb_blend_en_i | (!rt_blend_en_i & !early_stepping_i);
  always @(posedge core_clk_i) begin
    prev_tk_q <= tk;
    prev_ce_q <= ce_i;
  end
  function automatic bit unit_ok(input logic [63:0] v);
    unit_ok = 1'b1;
    for (int i = 0; i < 4; i++)
      if (v[16*i +: 16] > `PBC_ONE) unit_ok = 1'b0;
  endfunction
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  chk_ready_gated: assert property (!ce_i |-> !in_ready_o)
    else $error("ready raised while clock enable low");
  chk_ready_when_empty: assert property (ce_i && !out_valid_o |-> in_ready_o)
    else $error("ready low with empty buffer");
  chk_output_hold: assert property (
    out_valid_o && !(out_ready_i && ce_i) |=> out_valid_o && $stable(out_color_o))
    else $error("result changed before it was popped");
  chk_reset_clear: assert property (
    $rose(rst_b_i) && $past(ce_i) |-> !out_valid_o && out_color_o == 64'h0)
    else $error("output not cleared by reset");
  chk_take_latency: assert property (tk && !out_valid_o ##1 ce_i |=> out_valid_o)
    else $error("result late after capture");
  chk_pass_thru: assert property (
    fresh && thru && !pre_clamp_en_i && rt_format_i == `PBC_FMT_FLOAT ##1 ce_i
    |=> out_color_o == $past(src_color_i, 2))
    else $error("unblended pixel altered");
  chk_int_clamp: assert property (
    fresh && thru && rt_format_i == `PBC_FMT_UINT ##1 ce_i
    |=> (out_color_o & 64'h8000_8000_8000_8000) == 64'h0)
    else $error("unsigned integer result negative");
  chk_unit_clamp: assert property (
    fresh && thru && pre_clamp_en_i && clamp_range_i == `PBC_RNG_UNIT
    && rt_format_i == `PBC_FMT_UNORM ##1 ce_i |=> unit_ok(out_color_o))
    else $error("clamped result outside unit range");
endmodule // pbc_blend_chk

bind pbc_blend pbc_blend_chk u_chk (
  .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
  .glb_blend_en_i(glb_blend_en_i), .pre_clamp_en_i(pre_clamp_en_i),
  .clamp_range_i(clamp_range_i), .early_stepping_i(early_stepping_i),
  .rt_blend_en_i(rt_blend_en_i), .rt_format_i(rt_format_i),
  .in_valid_i(in_valid_i), .in_ready_o(in_ready_o),
  .src_color_i(src_color_i), .out_valid_o(out_valid_o),
  .out_ready_i(out_ready_i), .out_color_o(out_color_o)
);

// ### verification/pbc_port_sink.sv
// Purpose: data port model that collects blended pixels
// Assumes: one pixel per accepted edge
// Notes: stall withholds ready so the skid buffer fills
`timescale 1ns/1ps
module pbc_port_sink (
  // Clock
  input wire core_clk_i,
  input wire ce_i,
  // Bench control
  input wire stall_i,
  // Pixel stream
  input wire out_valid_i,
  output wire out_ready_o,
  input wire [63:0] out_color_i
);
  logic [63:0] got[$];
  assign out_ready_o = !stall_i;
  always @(posedge core_clk_i) begin
    // A word only leaves the block on an enabled edge
    if (ce_i && out_valid_i && out_ready_o) begin
      got.push_back(out_color_i);
    end
  end
endmodule // pbc_port_sink

// ### verification/pbc_tb.sv
// Purpose: self-checking bench for the pre-blend clamp and blend stage
// Assumes: one pixel in flight per scenario except the buffer test
// Notes: expected values are hand-worked in Q3.12
`timescale 1ns/1ps
`include "pbc_regs.vh"
module tb;
  reg core_clk_i = 0;
  reg rst_b_i = 0;
  reg ce_i = 1;
  reg glb = 0, pce = 0, iae = 0, early = 0, vld = 0, dual = 0, rtb = 0;
  reg has_a = 1, stall = 0, tk = 0;
  reg [1:0] rng = 0;
  reg [2:0] cf = 0, af = 0, fmt = `PBC_FMT_FLOAT;
  reg [4:0] sf = 1, df = 1, saf = 1, daf = 1;
  reg [63:0] cc = 0, src = 0, s1 = 0, dst = 0;
  reg [79:0] fx = 80'h0400_0200_FE00_0200_0600;
  wire rdy, ov, ordy;
  wire [63:0] oc;
  integer errors = 0, num_checks = 0, i, k;
  pbc_blend uut (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .glb_blend_en_i(glb), .pre_clamp_en_i(pce), .clamp_range_i(rng),
    .ind_alpha_en_i(iae), .src_factor_i(sf), .dst_factor_i(df),
    .color_func_i(cf), .src_alpha_factor_i(saf),
    .dst_alpha_factor_i(daf), .alpha_func_i(af), .const_color_i(cc),
    .early_stepping_i(early), .in_valid_i(vld), .in_ready_o(rdy),
    .src_color_i(src), .second_source_output_i(s1),
    .dual_source_i(dual), .dst_color_i(dst), .rt_blend_en_i(rtb),
    .rt_format_i(fmt), .rt_has_alpha_i(has_a), .out_valid_o(ov),
    .out_ready_i(ordy), .out_color_o(oc)
  );
  pbc_port_sink sink (
    .core_clk_i(core_clk_i), .ce_i(ce_i), .stall_i(stall),
    .out_valid_i(ov),
    .out_ready_o(ordy), .out_color_i(oc)
  );
  always #10 core_clk_i = ~core_clk_i;
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  function [63:0] rep(input [15:0] v);
    rep = {4{v}};
  endfunction
  task tick;
    @(posedge core_clk_i);
    #1;
  endtask
  task chk(input [63:0] seen, input [63:0] exp, input string what);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("unexpected %0s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Offer one pixel, then wait a bounded time for its result
  task run(input [63:0] exp, input string what);
    integer n;
    vld = 1;
    for (n = 0; n < 50 && rdy !== 1'b1; n = n + 1) tick;
    tick;
    vld = 0;
    for (n = 0; n < 50 && sink.got.size() == 0; n = n + 1) tick;
    chk(sink.got.size() > 0 ? sink.got.pop_front() : 64'hX, exp, what);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_pass;
    src = 64'h1800_2000_F000_0800;
    iae = 1;
    run(src, "pass");
    pce = 1;
    fmt = `PBC_FMT_UNORM;
    run(64'h1000_1000_0000_0800, "unit clamp");
    fmt = `PBC_FMT_PSF;
    run(64'h1000_1000_0000_0800, "small float unit");
    rng = `PBC_RNG_TARGET;
    run(64'h1800_2000_0000_0800, "small float target");
    rng = `PBC_RNG_SIGNED;
    fmt = `PBC_FMT_SNORM;
    run(64'h1000_1000_F000_0800, "signed clamp");
    $display("test pass-through done");
  endtask
  task t_int;
    pce = 0;
    fmt = `PBC_FMT_UINT;
    run(64'h1800_2000_0000_0800, "uint");
    pce = 1;
    run(64'h1800_2000_0000_0800, "uint range");
    rng = `PBC_RNG_UNIT;
    fmt = `PBC_FMT_SINT;
    run(src, "sint");
    $display("test integer formats done");
  endtask
  task t_func;
    pce = 0;
    fmt = `PBC_FMT_FLOAT;
    glb = 1;
    rtb = 1;
    iae = 0;
    // Blends only with the global enable and the target enable or early stepping
    src = rep(16'h0400);
    dst = rep(16'h0200);
    for (i = 0; i < 5; i = i + 1) begin
      cf = i[2:0];
      run(rep(fx[16*i +: 16]), "function");
    end
    cf = `PBC_FN_ADD;
    rtb = 0;
    run(src, "target off");
    early = 1;
    run(rep(16'h0600), "early stepping");
    early = 0;
    rtb = 1;
    $display("test functions done");
  endtask
  task t_alpha;
    saf = `PBC_BF_ZERO;
    daf = `PBC_BF_ZERO;
    run(rep(16'h0600), "alpha shared");
    iae = 1;
    run(64'h0000_0600_0600_0600, "alpha own");
    iae = 0;
    has_a = 0;
    run(64'h1000_0600_0600_0600, "no alpha");
    sf = `PBC_BF_DST_A;
    df = `PBC_BF_ZERO;
    run(64'h1000_0400_0400_0400, "dst alpha one");
    has_a = 1;
    $display("test alpha done");
  endtask
  task t_factor;
    src = 64'h0800_0400_0400_0400;
    dst = 64'h0C00_0800_0800_0800;
    cc = 64'h0400_1000_1000_1000;
    sf = `PBC_BF_SRC_A;
    df = `PBC_BF_INV_SRC_A;
    run(64'h0A00_0600_0600_0600, "src alpha");
    sf = `PBC_BF_DST_C;
    df = `PBC_BF_INV_SRC_C;
    run(64'h0C00_0800_0800_0800, "dst colour");
    sf = `PBC_BF_SAT;
    df = `PBC_BF_INV_DST_A;
    run(64'h0B00_0300_0300_0300, "saturate");
    sf = `PBC_BF_INV_CC_C;
    df = `PBC_BF_CC_A;
    run(64'h0900_0200_0200_0200, "const alpha");
    sf = `PBC_BF_INV_CC_A;
    df = `PBC_BF_INV_DST_C;
    run(64'h0900_0700_0700_0700, "inv const");
    sf = `PBC_BF_SRC_C;
    df = `PBC_BF_ZERO;
    run(64'h0400_0100_0100_0100, "src colour");
    iae = 1;
    saf = `PBC_BF_ONE;
    daf = `PBC_BF_ONE;
    af = `PBC_FN_RSUB;
    sf = `PBC_BF_ONE;
    run(rep(16'h0400), "alpha function");
    iae = 0;
    af = `PBC_FN_ADD;
    $display("test blend factors done");
  endtask
  task t_dual;
    // Second-source factors only with dual messages while blending
    sf = `PBC_BF_S1_C;
    dual = 1;
    src = rep(16'h1000);
    s1 = rep(16'h0800);
    run(rep(16'h0800), "second colour");
    sf = `PBC_BF_INV_S1_A;
    s1 = {16'h0C00, 48'h0};
    run(rep(16'h0400), "second alpha");
    sf = `PBC_BF_S1_A;
    df = `PBC_BF_INV_S1_C;
    run(64'h0F00_1400_1400_1400, "second mixed");
    dual = 0;
    $display("test dual source done");
  endtask
  task t_clamp;
    sf = `PBC_BF_ONE;
    df = `PBC_BF_ONE;
    src = rep(16'h2000);
    dst = rep(16'h2000);
    run(rep(16'h4000), "no pre-clamp");
    pce = 1;
    fmt = `PBC_FMT_UNORM;
    run(rep(16'h2000), "pre-clamp");
    sf = `PBC_BF_CC_C;
    df = `PBC_BF_ZERO;
    cc = rep(16'h2000);
    src = rep(16'h0800);
    run(rep(16'h0800), "const clamp");
    pce = 0;
    fmt = `PBC_FMT_FLOAT;
    run(rep(16'h1000), "const raw");
    $display("test pre-blend clamp done");
  endtask
  task t_buf;
    glb = 0;
    stall = 1;
    k = 0;
    src = 64'h0;
    vld = 1;
    for (i = 0; i < 8; i = i + 1) begin
      tk = rdy === 1'b1;
      tick;
      if (tk) begin
        k = k + 1;
        src = 64'(k);
      end
    end
    vld = 0;
    chk(64'(k), 64'h3, "accepted while stalled");
    ce_i = 0;
    tick;
    chk({63'h0, rdy}, 64'h0, "ready while frozen");
    ce_i = 1;
    stall = 0;
    repeat (4) tick;
    chk(64'(sink.got.size()), 64'h3, "drained count");
    for (i = 0; i < 3; i = i + 1)
      chk(sink.got.pop_front(), 64'(i), "order");
    $display("test buffer done");
  endtask
  initial begin
    repeat (10) @(posedge core_clk_i);
    #1;
    rst_b_i = 1;
    t_pass;
    t_int;
    t_func;
    t_alpha;
    t_factor;
    t_dual;
    t_clamp;
    t_buf;
    conclude;
  end
  initial begin
    #200000;
    errors = errors + 1;
    conclude;
  end
endmodule // tb
